// >>> pkg/bmc_map.vh
// Constants for the battery mode controller: register offsets, flag
// positions, reset values and timing counts.
// Assumes inclusion by the controller and its self-checking bench.
`ifndef BMC_MAP_VH
`define BMC_MAP_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define BMC_FLAGS_ADDR      8'hE8
`define BMC_FLAGS_RESET     8'h00
`define BMC_PLL_LOST_BIT    7
`define BMC_PLL_LOCKED_BIT  6
`define BMC_TIMER_WAKE_BIT  5
`define BMC_BUTTON_WAKE_BIT 4
`define BMC_KEEP_ADDR_BASE  8'hF0
`define BMC_KEEP_COUNT      8
`define BMC_KEEP_RESET      8'h00
`define BMC_CTRL_ADDR       8'hE9
`define BMC_CTRL_RESET      8'h00
`define BMC_STAT_ADDR       8'hEA

// ----------------------------------------------------------------
// Timing in slow-clock cycles
// ----------------------------------------------------------------
`define BMC_LOCK_MIN_CYC    2048
`define BMC_LOCK_MAX_CYC    4096
`define BMC_WAKE_MAX_CYC    3
// Brownout processor clock: 7 pulses out of every 8 slow-clock ticks
`define BMC_BROWN_NUM       7
`define BMC_BROWN_DEN       8

`endif

// >>> src/bmc_ctrl.v
// Operating-mode controller: full power, brownout, display-only, sleep.
// Assumes CORE_CLK_I is the slow clock enable domain (20 MHz core clock with
// a slow-clock tick input), register access over a simple SFR port.
`timescale 1ns/10ps
`include "bmc_map.vh"

module bmc_ctrl #(
    parameter LOCK_CYCLES = `BMC_LOCK_MIN_CYC,
    parameter DIV_WIDTH   = 3
) (
    input  wire                 CORE_CLK_I,
    input  wire                 RESET_I,
    input  wire                 SLOW_TICK_I,
    input  wire                 POWER_COMPARATOR_I,
    input  wire                 BATTERY_MARGIN_GOOD_I,
    input  wire                 PUSHBUTTON_INPUT_I,
    input  wire                 WAKE_TIMER_EXPIRED_I,
    input  wire                 SFR_WR_I,
    input  wire                 SFR_RD_I,
    input  wire [7:0]           SFR_ADDR_I,
    input  wire [7:0]           SFR_WDATA_I,
    input  wire [DIV_WIDTH-1:0] CPU_CLOCK_DIVIDER_I,
    output reg  [7:0]           SFR_RDATA_O,
    output wire                 FULL_POWER_MODE_O,
    output wire                 BROWNOUT_MODE_O,
    output wire                 DISPLAY_ONLY_MODE_O,
    output wire                 SLEEP_MODE_O,
    output wire                 CLOCK_STABLE_O,
    output wire                 CPU_RESET_O,
    output reg                  CPU_CLK_EN_O,
    output wire [DIV_WIDTH-1:0] CPU_DIVIDER_USED_O,
    output wire                 DIGITAL_PERIPH_EN_O,
    output wire                 METERING_EN_O,
    output wire                 DISPLAY_EN_O,
    output wire                 SEGMENT_BLINK_EN_O,
    output wire                 ADC_EN_O,
    output wire                 ENGINE_EN_O,
    output wire                 ENGINE_PC_CLEAR_O,
    output wire                 WAKE_TIMER_RUN_O
);

    // ------------------------------------------------------------
    // Mode states, one-hot
    // ------------------------------------------------------------
    localparam [3:0] ST_FULL  = 4'h1;
    localparam [3:0] ST_BROWN = 4'h2;
    localparam [3:0] ST_DISP  = 4'h4;
    localparam [3:0] ST_SLEEP = 4'h8;

    localparam [12:0] LOCK_CNT = LOCK_CYCLES;
    localparam [1:0]  WAKE_CNT = `BMC_WAKE_MAX_CYC - 1;

    reg  [3:0]           mode_q;
    reg  [3:0]           mode_d;
    reg  [12:0]          lock_cnt_q;
    reg                  lock_q;
    reg                  lock_prev_q;
    reg  [7:0]           flags_q;
    reg  [7:0]           ctrl_q;
    reg                  margin_lost_q;
    reg                  btn_prev_q;
    reg                  wake_hold_q;
    reg  [1:0]           wake_cnt_q;
    reg  [2:0]           frac_q;
    reg  [DIV_WIDTH-1:0] div_keep_q;
    reg  [7:0]           keep_q [0:`BMC_KEEP_COUNT-1];

    wire [1:0] sync_out;
    wire       power_ok;
    wire       margin_ok;
    wire       btn_rise;
    wire       wake_event;
    wire       flags_wr;
    wire       ctrl_wr;

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    // synchronise comparator inputs
    bmc_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_i   (CORE_CLK_I),
        .rst_i   (RESET_I),
        .async_i ({BATTERY_MARGIN_GOOD_I, POWER_COMPARATOR_I}),
        .sync_o  (sync_out)
    );

    assign power_ok  = sync_out[0];
    assign margin_ok = sync_out[1];

    // Button edge, seen only in display-only and sleep as a wake source
    assign btn_rise   = PUSHBUTTON_INPUT_I & ~btn_prev_q;
    assign wake_event = btn_rise | WAKE_TIMER_EXPIRED_I;
    assign flags_wr   = SFR_WR_I && (SFR_ADDR_I == `BMC_FLAGS_ADDR);
    assign ctrl_wr    = SFR_WR_I && (SFR_ADDR_I == `BMC_CTRL_ADDR);

    // ------------------------------------------------------------
    // Clock-stable timer
    // ------------------------------------------------------------
    // lock only after the settle count of slow ticks
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            lock_cnt_q  <= 13'h0000;
            lock_q      <= 1'b0;
            lock_prev_q <= 1'b0;
        end else begin
            lock_prev_q <= lock_q;
            if (!power_ok) begin
                lock_cnt_q <= 13'h0000;
                lock_q     <= 1'b0;
            end else if (SLOW_TICK_I && !lock_q) begin
                if (lock_cnt_q == LOCK_CNT - 13'h0001) begin
                    lock_q <= 1'b1;
                end
                lock_cnt_q <= lock_cnt_q + 13'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    always @* begin
        mode_d = mode_q;
        case (mode_q)
            ST_FULL: begin
                if (!power_ok) begin
                    mode_d = ST_BROWN;
                end
            end
            ST_BROWN: begin
                // back to full power once locked
                if (lock_q) begin
                    mode_d = ST_FULL;
                end else if (!margin_ok || margin_lost_q) begin
                    mode_d = ST_SLEEP;
                end else if (ctrl_q[1]) begin
                    mode_d = ST_SLEEP;
                end else if (ctrl_q[0]) begin
                    mode_d = ST_DISP;
                end
            end
            ST_DISP, ST_SLEEP: begin
                // power, timer or button leave; display-only also drops to sleep on margin loss
                if (lock_q) begin
                    mode_d = ST_FULL;
                end else if (wake_event && !margin_lost_q && margin_ok) begin
                    mode_d = ST_BROWN;
                end else if (mode_q == ST_DISP && (!margin_ok || margin_lost_q)) begin
                    mode_d = ST_SLEEP;
                end
            end
            default: begin
                mode_d = ST_BROWN;
            end
        endcase
    end

    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            mode_q <= ST_BROWN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // latch margin loss until power returns
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            margin_lost_q <= 1'b0;
        end else if (power_ok) begin
            margin_lost_q <= 1'b0;
        end else if (!margin_ok) begin
            margin_lost_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Event flags and control register
    // ------------------------------------------------------------
    // Hardware set beats a software clear in the same cycle
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            flags_q    <= `BMC_FLAGS_RESET;
            btn_prev_q <= 1'b0;
        end else begin
            btn_prev_q <= PUSHBUTTON_INPUT_I;
            if (flags_wr) begin
                flags_q <= flags_q & SFR_WDATA_I;  // Write zero to clear
            end
            // lost on full power to brownout
            if (mode_q == ST_FULL && mode_d == ST_BROWN) begin
                flags_q[`BMC_PLL_LOST_BIT] <= 1'b1;
            end
            // locked on return to full power
            if (mode_q != ST_FULL && mode_d == ST_FULL) begin
                flags_q[`BMC_PLL_LOCKED_BIT] <= 1'b1;
            end
            if (WAKE_TIMER_EXPIRED_I) begin
                flags_q[`BMC_TIMER_WAKE_BIT] <= 1'b1;
            end
            if (btn_rise) begin
                flags_q[`BMC_BUTTON_WAKE_BIT] <= 1'b1;
            end
        end
    end

    // Requests act once; cleared on leaving brownout
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            ctrl_q <= `BMC_CTRL_RESET;
        end else if (mode_q == ST_BROWN && mode_d != ST_BROWN) begin
            ctrl_q <= `BMC_CTRL_RESET;
        end else if (ctrl_wr && mode_q == ST_BROWN) begin
            ctrl_q <= {6'h00, SFR_WDATA_I[1:0]};
        end
    end

    // ------------------------------------------------------------
    // Keep registers
    // ------------------------------------------------------------
    // cleared only by hardware reset
    genvar gi;
    generate
        for (gi = 0; gi < `BMC_KEEP_COUNT; gi = gi + 1) begin : g_keep
            always @(posedge CORE_CLK_I) begin
                if (RESET_I) begin
                    keep_q[gi] <= `BMC_KEEP_RESET;
                end else if (SFR_WR_I && SFR_ADDR_I == `BMC_KEEP_ADDR_BASE + gi) begin
                    keep_q[gi] <= SFR_WDATA_I;
                end
            end
        end
    endgenerate

    // Read mux, unmapped reads zero
    always @* begin
        SFR_RDATA_O = 8'h00;
        if (!SFR_RD_I) begin
            SFR_RDATA_O = 8'h00;
        end else if (SFR_ADDR_I == `BMC_FLAGS_ADDR) begin
            SFR_RDATA_O = {flags_q[7:4], 4'h0};
        end else if (SFR_ADDR_I == `BMC_CTRL_ADDR) begin
            SFR_RDATA_O = ctrl_q;
        end else if (SFR_ADDR_I == `BMC_STAT_ADDR) begin
            SFR_RDATA_O = {3'h0, power_ok, mode_q};
        end else if (SFR_ADDR_I[7:3] == `BMC_KEEP_ADDR_BASE >> 3) begin
            SFR_RDATA_O = keep_q[SFR_ADDR_I[2:0]];
        end
    end

    // ------------------------------------------------------------
    // Processor run control
    // ------------------------------------------------------------
    // wake holds reset then releases within three ticks
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            wake_hold_q <= 1'b0;
            wake_cnt_q  <= 2'h0;
        end else if ((mode_q == ST_DISP || mode_q == ST_SLEEP) && mode_d == ST_BROWN) begin
            wake_hold_q <= 1'b1;
            wake_cnt_q  <= WAKE_CNT;
        end else if (wake_hold_q && SLOW_TICK_I) begin
            if (wake_cnt_q == 2'h0) begin
                wake_hold_q <= 1'b0;
            end else begin
                wake_cnt_q <= wake_cnt_q - 2'h1;
            end
        end
    end

    // held reset restarts the processor from 0x0000
    // power back but not locked keeps the processor held
    assign CPU_RESET_O = mode_q[2] | mode_q[3] | wake_hold_q | (power_ok & ~lock_q);

    // 7 of 8 slow ticks in brownout
    // this rate bounds serial ports at 300 baud
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            frac_q       <= 3'h0;
            CPU_CLK_EN_O <= 1'b0;
        end else begin
            CPU_CLK_EN_O <= 1'b0;
            if (mode_q == ST_BROWN && SLOW_TICK_I && !wake_hold_q) begin
                frac_q       <= frac_q + 3'h1;
                CPU_CLK_EN_O <= (frac_q != 3'h7);
            end
        end
    end

    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            div_keep_q <= {DIV_WIDTH{1'b0}};
        end else if (mode_q == ST_FULL) begin
            div_keep_q <= CPU_CLOCK_DIVIDER_I;
        end
    end
    assign CPU_DIVIDER_USED_O = div_keep_q;

    // ------------------------------------------------------------
    // Function gating per mode
    // ------------------------------------------------------------
    assign FULL_POWER_MODE_O   = mode_q[0];
    assign BROWNOUT_MODE_O     = mode_q[1];
    assign DISPLAY_ONLY_MODE_O = mode_q[2];
    assign SLEEP_MODE_O        = mode_q[3];
    assign CLOCK_STABLE_O      = lock_q;

    // peripherals on, metering off in brownout
    assign DIGITAL_PERIPH_EN_O = mode_q[0] | mode_q[1];
    assign METERING_EN_O       = mode_q[0] & lock_q;
    assign DISPLAY_EN_O        = mode_q[0] | mode_q[1] | mode_q[2];
    assign SEGMENT_BLINK_EN_O  = mode_q[2];
    assign ADC_EN_O            = METERING_EN_O;
    assign ENGINE_EN_O         = METERING_EN_O;
    assign ENGINE_PC_CLEAR_O   = lock_prev_q & ~lock_q;
    assign WAKE_TIMER_RUN_O    = 1'b1;

endmodule // bmc_ctrl

// >>> src/bmc_sync.v
// Two-flop synchroniser for level inputs of the mode controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps

module bmc_sync #(
    parameter WIDTH = 2
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage read only by second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // bmc_sync

// >>> tb/bmc_ctrl_chk.sv
// Port checker for the battery mode controller.
// Assumes the bench gives one slow tick every 4 core cycles.
`timescale 1ns/10ps

module bmc_ctrl_chk #(
    parameter DIV_WIDTH = 3
) (
    input wire                 CORE_CLK_I,
    input wire                 RESET_I,
    input wire                 POWER_COMPARATOR_I,
    input wire                 PUSHBUTTON_INPUT_I,
    input wire                 WAKE_TIMER_EXPIRED_I,
    input wire                 FULL_POWER_MODE_O,
    input wire                 BROWNOUT_MODE_O,
    input wire                 DISPLAY_ONLY_MODE_O,
    input wire                 SLEEP_MODE_O,
    input wire                 CLOCK_STABLE_O,
    input wire                 CPU_RESET_O,
    input wire                 CPU_CLK_EN_O,
    input wire [DIV_WIDTH-1:0] CPU_DIVIDER_USED_O,
    input wire                 METERING_EN_O,
    input wire                 ADC_EN_O,
    input wire                 ENGINE_EN_O,
    input wire                 ENGINE_PC_CLEAR_O
);
    // ----
    // Mode relations
    // ----
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    // Quiet low modes
    wire low_mode = DISPLAY_ONLY_MODE_O | SLEEP_MODE_O;

    a_one_mode: assert property ($onehot({FULL_POWER_MODE_O, BROWNOUT_MODE_O,
        DISPLAY_ONLY_MODE_O, SLEEP_MODE_O})) else $error("mode not one-hot");
    a_full_locked: assert property (FULL_POWER_MODE_O |-> CLOCK_STABLE_O)
        else $error("full power without lock");
    a_unlocked_off: assert property (!CLOCK_STABLE_O |-> !(ADC_EN_O | ENGINE_EN_O))
        else $error("converter or engine on while unlocked");
    a_pc_clear: assert property ($fell(CLOCK_STABLE_O) |-> ##[0:1] ENGINE_PC_CLEAR_O)
        else $error("no engine counter clear");
    a_meter_gate: assert property (!FULL_POWER_MODE_O |-> !METERING_EN_O)
        else $error("metering on in battery mode");
    a_div_frozen: assert property (!FULL_POWER_MODE_O && !$past(FULL_POWER_MODE_O)
        |-> $stable(CPU_DIVIDER_USED_O)) else $error("divider moved in battery mode");
    a_brown_clk: assert property (CPU_CLK_EN_O
        |-> BROWNOUT_MODE_O || $past(BROWNOUT_MODE_O)) else $error("clock pulse outside brownout");
    a_held_low: assert property (low_mode |-> CPU_RESET_O)
        else $error("processor runs in low mode");
    // Four quiet cycles cover the sync and edge-detect delay
    a_sleep_stays: assert property ((SLEEP_MODE_O && !POWER_COMPARATOR_I
        && !PUSHBUTTON_INPUT_I && !WAKE_TIMER_EXPIRED_I)[*4] |=> SLEEP_MODE_O)
        else $error("sleep left without cause");
    a_wake_run: assert property (BROWNOUT_MODE_O && $past(low_mode)
        |-> ##[0:16] !CPU_RESET_O) else $error("wake hold too long");
endmodule // bmc_ctrl_chk

bind bmc_ctrl bmc_ctrl_chk #(.DIV_WIDTH(DIV_WIDTH)) u_chk (
    .CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .POWER_COMPARATOR_I(POWER_COMPARATOR_I),
    .PUSHBUTTON_INPUT_I(PUSHBUTTON_INPUT_I), .WAKE_TIMER_EXPIRED_I(WAKE_TIMER_EXPIRED_I),
    .FULL_POWER_MODE_O(FULL_POWER_MODE_O), .BROWNOUT_MODE_O(BROWNOUT_MODE_O),
    .DISPLAY_ONLY_MODE_O(DISPLAY_ONLY_MODE_O), .SLEEP_MODE_O(SLEEP_MODE_O),
    .CLOCK_STABLE_O(CLOCK_STABLE_O), .CPU_RESET_O(CPU_RESET_O), .CPU_CLK_EN_O(CPU_CLK_EN_O),
    .CPU_DIVIDER_USED_O(CPU_DIVIDER_USED_O), .METERING_EN_O(METERING_EN_O),
    .ADC_EN_O(ADC_EN_O), .ENGINE_EN_O(ENGINE_EN_O), .ENGINE_PC_CLEAR_O(ENGINE_PC_CLEAR_O));

// >>> tb/bmc_ctrl_tb_top.sv
// Self-checking bench for the battery mode controller.
// Assumes a slow tick every 4 core cycles and a lock count of 4 ticks.
`timescale 1ns/10ps
`include "bmc_map.vh"

module bmc_ctrl_tb_top;
    // ----
    // Signals and design
    // ----
    localparam [3:0] M_FULL = 4'h8, M_BRN = 4'h4, M_DSP = 4'h2, M_SLP = 4'h1;
    reg        clk, rst, comp, margin, btn, tmr, wr, rd;
    reg        tick = 1'b0;
    reg  [1:0] tc = 2'h0;
    reg  [7:0] addr, wdata, i;
    reg  [2:0] div;
    wire [7:0] rdata;
    wire [2:0] div_used;
    wire       full, brown, disp, slp, lock, cpu_rst, clk_en;
    wire       dig_en, met_en, dsp_en, adc_en, eng_en, blink, tmr_run;
    wire [3:0] mode = {full, brown, disp, slp};
    integer    n_fail, compares, k;

    bmc_ctrl #(.LOCK_CYCLES(4), .DIV_WIDTH(3)) DUT (
        .CORE_CLK_I(clk), .RESET_I(rst), .SLOW_TICK_I(tick), .POWER_COMPARATOR_I(comp),
        .BATTERY_MARGIN_GOOD_I(margin), .PUSHBUTTON_INPUT_I(btn), .WAKE_TIMER_EXPIRED_I(tmr),
        .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata),
        .CPU_CLOCK_DIVIDER_I(div), .SFR_RDATA_O(rdata), .FULL_POWER_MODE_O(full),
        .BROWNOUT_MODE_O(brown), .DISPLAY_ONLY_MODE_O(disp), .SLEEP_MODE_O(slp),
        .CLOCK_STABLE_O(lock), .CPU_RESET_O(cpu_rst), .CPU_CLK_EN_O(clk_en),
        .CPU_DIVIDER_USED_O(div_used), .DIGITAL_PERIPH_EN_O(dig_en), .METERING_EN_O(met_en),
        .DISPLAY_EN_O(dsp_en), .SEGMENT_BLINK_EN_O(blink), .ADC_EN_O(adc_en),
        .ENGINE_EN_O(eng_en), .ENGINE_PC_CLEAR_O(), .WAKE_TIMER_RUN_O(tmr_run));

    // 20 MHz core clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Slow tick shortened to every 4th cycle to keep the run brief
    always @(posedge clk) begin
        #1;
        tc = tc + 2'h1;
        tick = (tc == 2'h0);
    end

    // ----
    // Access tasks
    // ----
    task step; begin
        @(posedge clk);
        #1;
    end endtask
    task chk(input [7:0] got, input [7:0] exp); begin
        compares = compares + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end endtask
    task wr_sfr(input [7:0] a, input [7:0] d); begin
        step;
        wr = 1'b1;
        addr = a;
        wdata = d;
        step;
        wr = 1'b0;
    end endtask
    // Read data is combinational, so sample mid-cycle
    task rd_sfr(input [7:0] a, input [7:0] m, input [7:0] e); begin
        step;
        rd = 1'b1;
        addr = a;
        #20;
        chk(rdata & m, e);
        step;
        rd = 1'b0;
    end endtask
    task complete_run; begin
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    end endtask
    task wait_mode(input [3:0] m, output integer n); begin
        n = 0;
        while (mode !== m && n < 500) begin
            step;
            n = n + 1;
        end
        if (n >= 500) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: mode wait timed out", $time);
            complete_run;
        end
    end endtask
    // Hold after wake is three ticks, twelve cycles here
    task wait_run; begin
        k = 0;
        while (cpu_rst !== 1'b0 && k < 16) begin
            step;
            k = k + 1;
        end
        chk({7'h00, cpu_rst}, 8'h00);
    end endtask

    // ----
    // Scenarios
    // ----
    initial begin
        n_fail = 0;
        compares = 0;
        {rst, comp, btn, tmr, wr, rd, margin} = 7'h41;
        addr = 8'h00;
        wdata = 8'h00;
        div = 3'h0;
        repeat (10) step;
        rst = 1'b0;
        chk({4'h0, mode}, M_BRN);
        rd_sfr(`BMC_FLAGS_ADDR, 8'hF0, 8'h00);
        rd_sfr(`BMC_CTRL_ADDR, 8'h03, 8'h00);
        rd_sfr(8'h10, 8'hFF, 8'h00);
        for (i = 8'h00; i < 8'h08; i = i + 8'h01) begin
            rd_sfr(`BMC_KEEP_ADDR_BASE + i, 8'hFF, 8'h00);
            wr_sfr(`BMC_KEEP_ADDR_BASE + i, 8'hA0 + i);
        end
        // Power returns: full power only after the lock count
        comp = 1'b1;
        repeat (4) step;
        chk({7'h00, cpu_rst}, 8'h01);
        wait_mode(M_FULL, k);
        chk({7'h00, (k + 4) >= 12}, 8'h01);
        chk({6'h00, lock, cpu_rst}, 8'h02);
        rd_sfr(`BMC_FLAGS_ADDR, 8'hF0, 8'h40);
        div = 3'h5;
        repeat (4) step;
        chk({5'h00, div_used}, 8'h05);
        wr_sfr(`BMC_FLAGS_ADDR, 8'h00);
        // Power lost: brownout gating and 7 of 8 clock pulses
        comp = 1'b0;
        wait_mode(M_BRN, k);
        rd_sfr(`BMC_FLAGS_ADDR, 8'hF0, 8'h80);
        chk({6'h00, adc_en, eng_en}, 8'h00);
        chk({4'h0, dig_en, dsp_en, met_en, blink}, 8'h0C);
        div = 3'h2;
        k = 0;
        repeat (32) begin
            step;
            k = k + clk_en;
        end
        chk(k[7:0], 8'h07);
        chk({5'h00, div_used}, 8'h05);
        rd_sfr(8'hF3, 8'hFF, 8'hA3);
        // Sleep, then timer wake
        wr_sfr(`BMC_FLAGS_ADDR, 8'h00);
        wr_sfr(`BMC_CTRL_ADDR, 8'h03);
        wait_mode(M_SLP, k);
        repeat (40) step;
        chk({4'h0, mode}, M_SLP);
        chk({5'h00, dig_en, dsp_en, tmr_run}, 8'h01);
        tmr = 1'b1;
        step;
        tmr = 1'b0;
        wait_mode(M_BRN, k);
        wait_run;
        rd_sfr(`BMC_FLAGS_ADDR, 8'hF0, 8'h20);
        rd_sfr(`BMC_CTRL_ADDR, 8'h03, 8'h00);
        // Display-only, then button wake
        wr_sfr(`BMC_FLAGS_ADDR, 8'h00);
        wr_sfr(`BMC_CTRL_ADDR, 8'h01);
        wait_mode(M_DSP, k);
        chk({5'h00, cpu_rst, dsp_en, blink}, 8'h07);
        btn = 1'b1;
        wait_mode(M_BRN, k);
        btn = 1'b0;
        wait_run;
        rd_sfr(`BMC_FLAGS_ADDR, 8'hF0, 8'h10);
        wr_sfr(`BMC_FLAGS_ADDR, 8'h00);
        // Margin loss forces sleep, which sticks until power returns
        margin = 1'b0;
        wait_mode(M_SLP, k);
        margin = 1'b1;
        repeat (40) step;
        chk({4'h0, mode}, M_SLP);
        // Wake sources refused once margin loss has latched
        tmr = 1'b1;
        step;
        tmr = 1'b0;
        btn = 1'b1;
        repeat (8) step;
        btn = 1'b0;
        chk({4'h0, mode}, M_SLP);
        wr_sfr(`BMC_FLAGS_ADDR, 8'h00);
        comp = 1'b1;
        wait_mode(M_FULL, k);
        rd_sfr(`BMC_STAT_ADDR, 8'h10, 8'h10);
        rd_sfr(`BMC_FLAGS_ADDR, 8'hF0, 8'h40);
        // Request refused outside brownout
        wr_sfr(`BMC_CTRL_ADDR, 8'h01);
        repeat (8) step;
        chk({4'h0, mode}, M_FULL);
        rd_sfr(`BMC_CTRL_ADDR, 8'h03, 8'h00);
        rd_sfr(8'hF7, 8'hFF, 8'hA7);
        rst = 1'b1;
        repeat (2) step;
        rst = 1'b0;
        rd_sfr(8'hF7, 8'hFF, 8'h00);
        complete_run;
    end
endmodule // bmc_ctrl_tb_top
